// *** core/abc_ctrl.sv ***
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module abc_ctrl
  import abc_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic rx_start_i,
  input wire logic preamble_det_i,
  input wire logic sync_det_i,
  input wire logic bit_tick_i,
  input wire logic afc_corr_req_i,
  input wire logic [9:0] afc_corr_i,
  input wire logic ant_switch_i,
  output logic afc_corr_ok_o,
  output logic [9:0] afc_tol_o,
  output logic ant_wait_o,
  output logic [10:0] loop_gain_o,
  output abc_afc_cfg_t afc_cfg_o,
  output abc_bcr_cfg_t bcr_cfg_o
);
  logic [7:0] afc_gear_override_ff;
  logic [7:0] afc_timing_control_ff;
  logic [7:0] bit_clock_gear_override_ff;
  logic [7:0] oversampling_ratio_low_ff;
  logic [7:0] recovery_offset_upper_ff;
  logic [7:0] recovery_offset_middle_ff;
  logic [7:0] recovery_offset_lower_ff;
  logic [7:0] timing_loop_gain_upper_ff;
  logic [7:0] timing_loop_gain_lower_ff;
  logic [9:0] afc_result_ff;
  logic afc_latched_ff;
  abc_state_t state_ff;
  abc_state_t nxt_state;
  logic [10:0] loop_gain_ff;
  logic [9:0] afc_tol_ff;
  logic [31:0] prdata_ff;
  logic wr_en;
  logic rd_en;
  logic [7:0] idx;
  logic short_busy;
  logic short_done;
  logic [4:0] short_bits;
  logic [2:0] shwait;
  logic ant_busy;

  // Only word-aligned addresses map; index is byte address over four
  function automatic logic mapped(input logic [11:0] a);
    logic [7:0] i;
    i = a[9:2];
    return (a[1:0] == 2'b00) && (a[11:10] == 2'b00) &&
      ((i >= IDX_AFC_GEAR && i <= IDX_GAIN_LOW) ||
       i == IDX_AFC_RES_HI || i == IDX_AFC_RES_LO || i == IDX_STATUS);
  endfunction : mapped

  assign idx = paddr_i[9:2];
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped(paddr_i);
  assign wr_en = psel_i && penable_i && pwrite_i && mapped(paddr_i);
  assign rd_en = psel_i && !penable_i && !pwrite_i;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      afc_gear_override_ff <= RST_AFC_GEAR;
      afc_timing_control_ff <= RST_AFC_TIME;
      bit_clock_gear_override_ff <= RST_BCR_GEAR;
      oversampling_ratio_low_ff <= RST_OSR_LOW;
      recovery_offset_upper_ff <= RST_OFS_UP;
      recovery_offset_middle_ff <= RST_OFS_MID;
      recovery_offset_lower_ff <= RST_OFS_LOW;
      timing_loop_gain_upper_ff <= RST_GAIN_UP;
      timing_loop_gain_lower_ff <= RST_GAIN_LOW;
    end else if (wr_en) begin
      case (idx)
        IDX_AFC_GEAR: afc_gear_override_ff <= pwdata_i[7:0];
        IDX_AFC_TIME: begin
          afc_timing_control_ff <= pwdata_i[7:0] & MASK_AFC_TIME;
        end
        IDX_BCR_GEAR: begin
          bit_clock_gear_override_ff <= pwdata_i[7:0] & MASK_BCR_GEAR;
        end
        IDX_OSR_LOW: oversampling_ratio_low_ff <= pwdata_i[7:0];
        IDX_OFS_UP: recovery_offset_upper_ff <= pwdata_i[7:0];
        IDX_OFS_MID: recovery_offset_middle_ff <= pwdata_i[7:0];
        IDX_OFS_LOW: recovery_offset_lower_ff <= pwdata_i[7:0];
        IDX_GAIN_UP: begin
          timing_loop_gain_upper_ff <= pwdata_i[7:0] & MASK_GAIN_UP;
        end
        IDX_GAIN_LOW: timing_loop_gain_lower_ff <= pwdata_i[7:0];
        default: ;
      endcase
    end
  end

  // Read data captured in setup so the access phase answers at once
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata_ff <= PSLVERR_DATA;
      if (mapped(paddr_i)) begin
        case (idx)
          IDX_AFC_GEAR: prdata_ff <= {24'h0, afc_gear_override_ff};
          IDX_AFC_TIME: prdata_ff <= {24'h0, afc_timing_control_ff};
          IDX_BCR_GEAR: prdata_ff <= {24'h0, bit_clock_gear_override_ff};
          IDX_OSR_LOW: prdata_ff <= {24'h0, oversampling_ratio_low_ff};
          IDX_OFS_UP: prdata_ff <= {24'h0, recovery_offset_upper_ff};
          IDX_OFS_MID: prdata_ff <= {24'h0, recovery_offset_middle_ff};
          IDX_OFS_LOW: prdata_ff <= {24'h0, recovery_offset_lower_ff};
          IDX_GAIN_UP: prdata_ff <= {24'h0, timing_loop_gain_upper_ff};
          IDX_GAIN_LOW: prdata_ff <= {24'h0, timing_loop_gain_lower_ff};
          IDX_AFC_RES_HI: prdata_ff <= {24'h0, afc_result_ff[9:2]};
          IDX_AFC_RES_LO: prdata_ff <= {24'h0, afc_result_ff[1:0], 6'h00};
          IDX_STATUS: begin
            prdata_ff <= {29'h0, afc_latched_ff, state_ff};
          end
          default: prdata_ff <= PSLVERR_DATA;
        endcase
      end
    end
  end
  assign prdata_o = prdata_ff;

  // Preamble search state; restart always wins over detection
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ABC_IDLE: if (rx_start_i) nxt_state = ABC_SEARCH;
      ABC_SEARCH: begin
        if (rx_start_i) nxt_state = ABC_SEARCH;
        else if (preamble_det_i) nxt_state = ABC_LOCKED;
      end
      ABC_LOCKED: if (rx_start_i) nxt_state = ABC_SEARCH;
      default: nxt_state = ABC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) state_ff <= ABC_IDLE;
    else state_ff <= nxt_state;
  end

  // Gain shifted by the active gear; registered as a data output
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      loop_gain_ff <= 11'h000;
    end else if (state_ff == ABC_LOCKED) begin
      loop_gain_ff <= bcr_cfg_o.gain >> afc_cfg_o_gear(1'b0);
    end else begin
      loop_gain_ff <= bcr_cfg_o.gain >> afc_cfg_o_gear(1'b1);
    end
  end
  assign loop_gain_o = loop_gain_ff;

  function automatic logic [2:0] afc_cfg_o_gear(input logic fast);
    return fast ? bit_clock_gear_override_ff[5:3]
                : bit_clock_gear_override_ff[2:0];
  endfunction : afc_cfg_o_gear

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      afc_tol_ff <= AFC_TOL_BASE;
    end else if (afc_gear_override_ff[POS_HALVE]) begin
      afc_tol_ff <= AFC_TOL_BASE >> 1;
    end else begin
      afc_tol_ff <= AFC_TOL_BASE;
    end
  end
  assign afc_tol_o = afc_tol_ff;

  // Result freezes after the first sync of a reception
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      afc_result_ff <= 10'h000;
      afc_latched_ff <= 1'b0;
    end else if (rx_start_i) begin
      afc_latched_ff <= 1'b0;
    end else if (sync_det_i && !afc_latched_ff) begin
      afc_result_ff <= afc_corr_i;
      afc_latched_ff <= 1'b1;
    end
  end

  assign shwait = afc_timing_control_ff[5:3];
  assign short_bits = ({2'b00, shwait} + 5'h01) * {1'b0, BITS_PER_SHORT};

  // Correction allowed when enabled and locked, or searching with nonzero shwait and not in a hold-off wait
  always_comb begin
    afc_corr_ok_o = 1'b0;
    if (afc_gear_override_ff[POS_AFC_EN] && afc_corr_req_i) begin
      if (state_ff == ABC_LOCKED) afc_corr_ok_o = 1'b1;
      else if (state_ff == ABC_SEARCH && shwait != 3'h0 && !short_busy) begin
        afc_corr_ok_o = 1'b1;
      end
    end
  end

  abc_wait_timer u_short (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(afc_corr_ok_o && state_ff == ABC_SEARCH),
    .bits_i(short_bits),
    .bit_tick_i(bit_tick_i),
    .busy_o(short_busy),
    .done_o(short_done)
  );

  abc_wait_timer u_ant (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(ant_switch_i),
    .bits_i({2'b00, afc_timing_control_ff[2:0]}),
    .bit_tick_i(bit_tick_i),
    .busy_o(ant_busy),
    .done_o()
  );
  assign ant_wait_o = ant_busy;

  assign afc_cfg_o = '{halve: afc_gear_override_ff[POS_HALVE],
                       afc_en: afc_gear_override_ff[POS_AFC_EN],
                       gear_hi: afc_gear_override_ff[5:3],
                       gear_lo: afc_gear_override_ff[2:0]};
  assign bcr_cfg_o = '{
    osr: {recovery_offset_upper_ff[7:5], oversampling_ratio_low_ff},
    nco: {recovery_offset_upper_ff[3:0], recovery_offset_middle_ff,
          recovery_offset_lower_ff},
    stall: recovery_offset_upper_ff[POS_STALL],
    gain: {timing_loop_gain_upper_ff[2:0], timing_loop_gain_lower_ff},
    noise_imm: bit_clock_gear_override_ff[POS_NOISE]};

  a_tol_halved: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    afc_gear_override_ff[POS_HALVE] |=> afc_tol_o == (AFC_TOL_BASE >> 1))
    else $error("tolerance not halved");
  a_fast_gain: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_ff == ABC_SEARCH |=>
    loop_gain_o == ($past(bcr_cfg_o.gain) >>
                    $past(bit_clock_gear_override_ff[5:3])))
    else $error("fast gain wrong");
  a_slow_gain: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_ff == ABC_LOCKED |=>
    loop_gain_o == ($past(bcr_cfg_o.gain) >>
                    $past(bit_clock_gear_override_ff[2:0])))
    else $error("slow gain wrong");
  a_preamble_lock: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_ff == ABC_SEARCH && preamble_det_i && !rx_start_i |=>
    state_ff == ABC_LOCKED)
    else $error("preamble did not lock");
  a_halve_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !afc_gear_override_ff[POS_HALVE] |=> afc_tol_o == AFC_TOL_BASE)
    else $error("tolerance halved without request");
  a_lock_grant: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_ff == ABC_LOCKED && afc_gear_override_ff[POS_AFC_EN] &&
    afc_corr_req_i |-> afc_corr_ok_o)
    else $error("locked correction refused");
  a_sync_latch: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sync_det_i && !afc_latched_ff && !rx_start_i |=>
    afc_latched_ff && afc_result_ff == $past(afc_corr_i))
    else $error("afc result not latched");
  a_restart_fast: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rx_start_i |=> state_ff == ABC_SEARCH)
    else $error("restart not searching");
  a_no_corr_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_ff == ABC_SEARCH && shwait == 3'h0 |-> !afc_corr_ok_o)
    else $error("correction with zero wait");
  a_short_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    afc_corr_ok_o && state_ff == ABC_SEARCH && shwait != 3'h0 |=>
    short_busy)
    else $error("no hold-off after correction");
  a_result_frozen: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    afc_latched_ff && !rx_start_i |=> $stable(afc_result_ff))
    else $error("afc result changed");
  // Disabled in reset so the unreset first edge is not judged
  a_osr_reset: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $past(sys_rst_i) |-> bcr_cfg_o.osr == 11'h064 &&
    bcr_cfg_o.nco == 20'h100ae)
    else $error("reset values wrong");
  a_ant_wait: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ant_switch_i && afc_timing_control_ff[2:0] != 3'h0 |=> ant_wait_o)
    else $error("antenna wait missing");
  c_lock: cover property (@(posedge clk_i) state_ff == ABC_SEARCH ##1
    state_ff == ABC_LOCKED);
  c_latch: cover property (@(posedge clk_i) $rose(afc_latched_ff));
  c_short_done: cover property (@(posedge clk_i) short_done);
  c_ant_wait: cover property (@(posedge clk_i) $rose(ant_wait_o));
  c_relock: cover property (@(posedge clk_i) state_ff == ABC_LOCKED ##1
    state_ff == ABC_SEARCH);
endmodule : abc_ctrl

// *** shared/abc_pkg.sv ***
package abc_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam logic [7:0] IDX_AFC_GEAR = 8'h1d;
  localparam logic [7:0] IDX_AFC_TIME = 8'h1e;
  localparam logic [7:0] IDX_BCR_GEAR = 8'h1f;
  localparam logic [7:0] IDX_OSR_LOW = 8'h20;
  localparam logic [7:0] IDX_OFS_UP = 8'h21;
  localparam logic [7:0] IDX_OFS_MID = 8'h22;
  localparam logic [7:0] IDX_OFS_LOW = 8'h23;
  localparam logic [7:0] IDX_GAIN_UP = 8'h24;
  localparam logic [7:0] IDX_GAIN_LOW = 8'h25;
  localparam logic [7:0] IDX_AFC_RES_HI = 8'h2b;
  localparam logic [7:0] IDX_AFC_RES_LO = 8'h2c;
  localparam logic [7:0] IDX_STATUS = 8'h40;
  // Reset values
  localparam logic [7:0] RST_AFC_GEAR = 8'h00;
  localparam logic [7:0] RST_AFC_TIME = 8'h0a;
  localparam logic [7:0] RST_BCR_GEAR = 8'h03;
  localparam logic [7:0] RST_OSR_LOW = 8'h64;
  localparam logic [7:0] RST_OFS_UP = 8'h01;
  localparam logic [7:0] RST_OFS_MID = 8'h00;
  localparam logic [7:0] RST_OFS_LOW = 8'hae;
  localparam logic [7:0] RST_GAIN_UP = 8'h02;
  localparam logic [7:0] RST_GAIN_LOW = 8'h00;
  // Field positions
  localparam int unsigned POS_HALVE = 7;
  localparam int unsigned POS_AFC_EN = 6;
  localparam int unsigned POS_NOISE = 6;
  localparam int unsigned POS_STALL = 4;
  localparam int unsigned POS_HI_LSB = 3;
  localparam int unsigned POS_LO_LSB = 0;
  localparam int unsigned POS_OSR_UP = 5;
  localparam logic [7:0] MASK_AFC_TIME = 8'h3f;
  localparam logic [7:0] MASK_BCR_GEAR = 8'h7f;
  localparam logic [7:0] MASK_GAIN_UP = 8'h07;
  localparam logic [31:0] PSLVERR_DATA = 32'h0000_0000;
  // Base tolerance of the AFC loop, halved on request
  localparam logic [9:0] AFC_TOL_BASE = 10'h3ff;
  localparam logic [3:0] BITS_PER_SHORT = 4'h2;

  typedef enum logic [1:0] {
    ABC_IDLE = 2'b00,
    ABC_SEARCH = 2'b01,
    ABC_LOCKED = 2'b11
  } abc_state_t;

  typedef struct packed {
    logic halve;
    logic afc_en;
    logic [2:0] gear_hi;
    logic [2:0] gear_lo;
  } abc_afc_cfg_t;

  typedef struct packed {
    logic [10:0] osr;
    logic [19:0] nco;
    logic stall;
    logic [10:0] gain;
    logic noise_imm;
  } abc_bcr_cfg_t;
endpackage : abc_pkg

// *** core/abc_wait_timer.sv ***
`timescale 1ns/1ps
// Counts bit periods: load with a count, done pulses when it expires
module abc_wait_timer
  import abc_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic [4:0] bits_i,
  input wire logic bit_tick_i,
  output logic busy_o,
  output logic done_o
);
  // Five bits so the longest short wait of sixteen bits still fits
  logic [4:0] cnt_ff;
  logic busy_ff;
  logic done_ff;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_ff <= 5'h00;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start_i && bits_i != 5'h00) begin
        cnt_ff <= bits_i;
        busy_ff <= 1'b1;
      end else if (start_i) begin
        busy_ff <= 1'b0;
        done_ff <= 1'b1;
      end else if (busy_ff && bit_tick_i) begin
        if (cnt_ff == 5'h01) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
        cnt_ff <= cnt_ff - 5'h01;
      end
    end
  end

  assign busy_o = busy_ff;
  assign done_o = done_ff;
endmodule : abc_wait_timer

// *** tb/abc_ctrl_tb.sv ***
`timescale 1ns/1ps
module abc_ctrl_tb;
  import abc_pkg::*;
  logic clk_i = 1'b0, sys_rst_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, r;
  logic pready_o, pslverr_o, e;
  logic rx_start_i = 1'b0, preamble_det_i = 1'b0, sync_det_i = 1'b0;
  logic bit_tick_i = 1'b0, afc_corr_req_i = 1'b0, ant_switch_i = 1'b0;
  logic [9:0] afc_corr_i = 10'h000, afc_tol_o, v;
  logic afc_corr_ok_o, ant_wait_o, tick_en = 1'b0;
  logic [10:0] loop_gain_o;
  logic [1:0] tcnt = 2'b00;
  logic [7:0] sh [0:255];
  abc_afc_cfg_t afc_cfg_o;
  abc_bcr_cfg_t bcr_cfg_o;
  int n_mismatch = 0, n_checks = 0, c, g;

  abc_ctrl dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .rx_start_i(rx_start_i),
    .preamble_det_i(preamble_det_i), .sync_det_i(sync_det_i),
    .bit_tick_i(bit_tick_i), .afc_corr_req_i(afc_corr_req_i),
    .afc_corr_i(afc_corr_i), .ant_switch_i(ant_switch_i),
    .afc_corr_ok_o(afc_corr_ok_o), .afc_tol_o(afc_tol_o),
    .ant_wait_o(ant_wait_o), .loop_gain_o(loop_gain_o),
    .afc_cfg_o(afc_cfg_o), .bcr_cfg_o(bcr_cfg_o));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  // One bit period every four clocks, gated while idle
  always @(posedge clk_i) begin
    tcnt <= tcnt + 2'd1;
    bit_tick_i <= tick_en && (tcnt == 2'd3);
  end

  task report_and_stop;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int i;
    i = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= {2'b00, idx, 2'b00};
    pwdata_i <= {24'h0, wd};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      i++;
    end while (pready_o !== 1'b1 && i < 50);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (i >= 50) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask : apb

  function automatic logic [7:0] msk(input logic [7:0] idx);
    case (idx)
      8'h1e: return 8'h3f;
      8'h1f: return 8'h7f;
      8'h24: return 8'h07;
      default: return 8'hff;
    endcase
  endfunction : msk

  task wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
    sh[idx] = d & msk(idx);
  endtask : wr

  task rdchk(input logic [7:0] idx);
    apb(1'b0, idx, 8'h00);
    chk(r, {24'h0, sh[idx]});
  endtask : rdchk

  task cfgchk;
    chk(afc_cfg_o, sh[8'h1d]);
    chk(bcr_cfg_o.osr, {sh[8'h21][7:5], sh[8'h20]});
    chk(bcr_cfg_o.nco, {sh[8'h21][3:0], sh[8'h22], sh[8'h23]});
    chk(bcr_cfg_o.stall, sh[8'h21][4]);
    chk(bcr_cfg_o.gain, {sh[8'h24][2:0], sh[8'h25]});
    chk(bcr_cfg_o.noise_imm, sh[8'h1f][6]);
  endtask : cfgchk

  function automatic logic [10:0] exp_gain(input logic slow);
    logic [10:0] gn;
    gn = {sh[8'h24][2:0], sh[8'h25]};
    return gn >> (slow ? sh[8'h1f][2:0] : sh[8'h1f][5:3]);
  endfunction : exp_gain

  task pulse(input int w);
    @(posedge clk_i);
    case (w)
      0: rx_start_i <= 1'b1;
      1: preamble_det_i <= 1'b1;
      2: sync_det_i <= 1'b1;
      default: ant_switch_i <= 1'b1;
    endcase
    @(posedge clk_i);
    {rx_start_i, preamble_det_i, sync_det_i, ant_switch_i} <= 4'h0;
  endtask : pulse

  // Ticks seen between the first two grants; bounded window
  task meas;
    c = 0;
    g = 0;
    for (int k = 0; k < 200 && g < 2; k++) begin
      @(posedge clk_i);
      #1;
      if (afc_corr_ok_o === 1'b1) g++;
      else if (g == 1 && bit_tick_i === 1'b1) c++;
    end
  endtask : meas

  initial begin
    void'($urandom(89349));
    for (int k = 0; k < 256; k++) sh[k] = 8'h00;
    sh[8'h1d] = RST_AFC_GEAR;
    sh[8'h1e] = 8'h0a;
    sh[8'h1f] = 8'h03;
    sh[8'h20] = 8'h64;
    sh[8'h21] = 8'h01;
    sh[8'h22] = RST_OFS_MID;
    sh[8'h23] = 8'hae;
    sh[8'h24] = 8'h02;
    sh[8'h25] = RST_GAIN_LOW;
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    for (int k = 8'h1d; k <= 8'h25; k++) rdchk(k[7:0]);
    cfgchk();
    for (int k = 8'h1d; k <= 8'h25; k++) wr(k[7:0], 8'hff);
    for (int k = 8'h1d; k <= 8'h25; k++) rdchk(k[7:0]);
    cfgchk();
    repeat (30) wr(8'h1d + 8'($urandom_range(0, 8)), 8'($urandom));
    for (int k = 8'h1d; k <= 8'h25; k++) rdchk(k[7:0]);
    cfgchk();
    for (int k = 0; k < 2; k++) begin
      wr(8'h1d, {k[0], 7'($urandom)});
      repeat (3) @(posedge clk_i);
      chk(afc_tol_o, k[0] ? 10'h1ff : 10'h3ff);
    end
    apb(1'b0, 8'h30, 8'h00);
    chk({e, r}, 33'h1_0000_0000);
    // Loop gain gear shift, recommended and random gears
    for (int k = 0; k < 4; k++) begin
      wr(8'h24, 8'($urandom));
      wr(8'h25, 8'($urandom));
      wr(8'h1f, k == 0 ? 8'h05 : 8'($urandom));
      pulse(0);
      repeat (3) @(posedge clk_i);
      chk(loop_gain_o, exp_gain(1'b0));
      pulse(1);
      repeat (3) @(posedge clk_i);
      chk(loop_gain_o, exp_gain(1'b1));
      pulse(0);
      repeat (3) @(posedge clk_i);
      chk(loop_gain_o, exp_gain(1'b0));
    end
    tick_en <= 1'b1;
    wr(8'h1d, 8'h40);
    for (int n = 7; n >= 0; n -= 2) begin
      wr(8'h1e, {2'b00, n[2:0], 3'b000});
      pulse(0);
      afc_corr_req_i <= 1'b1;
      meas();
      chk(c, (n + 1) * 2);
      afc_corr_req_i <= 1'b0;
    end
    wr(8'h1e, 8'h00);
    pulse(0);
    afc_corr_req_i <= 1'b1;
    meas();
    chk(g, 0);
    pulse(1);
    repeat (2) @(posedge clk_i);
    #1;
    chk(afc_corr_ok_o, 1'b1);
    afc_corr_req_i <= 1'b0;
    for (int k = 0; k < 8; k += 3) begin
      wr(8'h1e, {5'b00001, k[2:0]});
      pulse(3);
      c = 0;
      // First look falls in the cycle the wait begins
      for (int j = 0; j < 100; j++) begin
        #1;
        if (ant_wait_o === 1'b1 && bit_tick_i === 1'b1) c++;
        @(posedge clk_i);
      end
      chk(c, k);
    end
    // Result must ignore a second sync in the same reception
    v = 10'($urandom);
    pulse(0);
    afc_corr_i <= v;
    pulse(2);
    afc_corr_i <= ~v;
    pulse(2);
    apb(1'b1, 8'h2b, 8'hff);
    apb(1'b0, 8'h2b, 8'h00);
    chk({e, r}, {25'h0, v[9:2]});
    apb(1'b0, 8'h2c, 8'h00);
    chk(r[7:0], {v[1:0], 6'h00});
    report_and_stop();
  end
endmodule : abc_ctrl_tb
